// ===== hdl/link_select.sv
`timescale 1ns/1ps
`include "loader_defs.svh"
module link_select (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire loader_pkg::link_byte_type a_rx,
    input  wire logic                     a_tx_ready,
    output loader_pkg::link_byte_type      a_tx,
    input  wire loader_pkg::link_byte_type b_rx,
    input  wire logic                     b_tx_ready,
    output loader_pkg::link_byte_type      b_tx,
    output loader_pkg::link_byte_type      rx,
    input  wire logic                     send,
    input  wire logic [7:0]               send_data,
    output logic                          busy
);
    import loader_pkg::*;

    typedef struct packed {
        logic [1:0]    lock;
        link_byte_type a_tx;
        link_byte_type b_tx;
    } sel_state_type;

    sel_state_type s_reg;
    sel_state_type s_next;
    logic          take_a;
    logic          take_b;

    // The first link to send a non-zero byte wins.
    assign take_a = s_reg.lock[0] | (s_reg.lock == 2'h0 & a_rx.valid & a_rx.data != `ZERO_BYTE);
    assign take_b = s_reg.lock[1] | (s_reg.lock == 2'h0 & ~take_a & b_rx.valid
                                     & b_rx.data != `ZERO_BYTE); // see R23
    assign rx.valid = (take_a & a_rx.valid) | (take_b & b_rx.valid);
    assign rx.data  = take_a ? a_rx.data : b_rx.data;
    assign busy     = s_reg.a_tx.valid | s_reg.b_tx.valid;
    assign a_tx     = s_reg.a_tx;
    assign b_tx     = s_reg.b_tx;

    // Lock and outgoing byte.
    always_comb begin
        s_next = s_reg;
        if (s_reg.lock == 2'h0) begin
            s_next.lock = {take_b, take_a};
        end
        if (s_reg.a_tx.valid & a_tx_ready) begin
            s_next.a_tx.valid = 1'b0;
        end
        if (s_reg.b_tx.valid & b_tx_ready) begin
            s_next.b_tx.valid = 1'b0;
        end
        if (send) begin
            s_next.a_tx.valid = s_reg.lock[0];
            s_next.b_tx.valid = s_reg.lock[1];
            s_next.a_tx.data  = send_data;
            s_next.b_tx.data  = send_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : link_select

// ===== hdl/loader_defs.svh
`ifndef LOADER_DEFS_SVH
`define LOADER_DEFS_SVH

// Command codes carried in the first payload byte.
`define CMD_PING          8'h20
`define CMD_DOWNLOAD      8'h21
`define CMD_RUN           8'h22
`define CMD_QUERY_RESULT  8'h23
`define CMD_SEND_DATA     8'h24
`define CMD_RESET         8'h25

// Acknowledge and filler bytes.
`define ACK_BYTE          8'hcc
`define NAK_BYTE          8'h33
`define ZERO_BYTE         8'h00

// Packet lengths, counting length and sum bytes.
`define LEN_PING          8'h03
`define LEN_QUERY_RESULT  8'h03
`define LEN_DOWNLOAD      8'h0b
`define LEN_RUN           8'h07
`define LEN_RESET         8'h03
`define LEN_REPLY         8'h03
`define LEN_MIN           8'h03
`define LEN_MAX           8'h12
`define HDR_BYTES         8'h02

// Result codes kept in the status register.
`define STAT_SUCCESS      8'h40
`define STAT_UNKNOWN_CMD  8'h41
`define STAT_INVALID_ARG  8'h42
`define STAT_FLASH_FAIL   8'h43
`define STAT_RESET        8'h00

// Payload buffer and flash geometry.
`define BUF_DEPTH         16
`define BUF_AW            4
`define PARAM_BYTES       8'h08
`define FLASH_BYTES       33'h0_0001_0000

// Reply sequence steps.
`define SEQ_ACK           2'h0
`define SEQ_SUM           2'h1
`define SEQ_DATA          2'h2
`define SEQ_DONE          2'h3

`endif

// ===== hdl/loader_pkg.sv
package loader_pkg;

    // One byte on a serial link, with its strobe.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } link_byte_type;

    // Requests towards the flash controller.
    typedef struct packed {
        logic        erase_req;
        logic        prog_req;
        logic [31:0] addr;
        logic [31:0] size;
        logic [7:0]  data;
    } flash_req_type;

    // Completion from the flash controller.
    typedef struct packed {
        logic done;
        logic ok;
    } flash_ans_type;

    // Hand-over requests.
    typedef struct packed {
        logic        run_req;
        logic        reset_req;
        logic [31:0] addr;
    } exec_type;

    typedef enum logic [10:0] {
        ST_IDLE      = 11'h001,
        ST_SUM       = 11'h002,
        ST_BODY      = 11'h004,
        ST_CHECK     = 11'h008,
        ST_ERASE     = 11'h010,
        ST_PROG_RD   = 11'h020,
        ST_PROG_LD   = 11'h040,
        ST_PROG_WAIT = 11'h080,
        ST_SEND      = 11'h100,
        ST_REPLY     = 11'h200,
        ST_HOLD      = 11'h400
    } state_type;

endpackage : loader_pkg

// ===== hdl/payload_mem.sv
`timescale 1ns/1ps
module payload_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Registered read; contents need no reset.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule : payload_mem

// ===== hdl/serial_loader.sv
`timescale 1ns/1ps
`include "loader_defs.svh"
// What this block does
// R1 - Byte one is the total length, header bytes counted.
// R2 - Byte two is the payload sum only.
// R3 - Payload is length minus two bytes.
// R4 - Answer is first non-zero byte: 0xcc good, 0x33 bad.
// R5 - Acknowledge covers framing, not the command.
// R6 - Reply packet: length, sum, payload.
// R7 - Reply bytes follow without filler.
// R8 - Host answers each reply; repeats command after a reject.
// R9 - Zeros before an answer are skipped.
// R10 - First payload byte is the command code.
// R11 - Ping is acknowledged and sets status to success.
// R12 - Status query returns the previous result in one byte.
// R13 - Setup carries address and count, high byte first.
// R14 - Setup erases the area before acknowledging.
// R15 - Setup status tells whether address and count are valid.
// R16 - Data writes follow setup or data write; address advances.
// R17 - Host sends at most eight bytes per data write.
// R18 - Programming stops at the announced byte count.
// R19 - A rejected data write keeps the address.
// R20 - Run is acknowledged before hand-over.
// R21 - Reset is acknowledged before the chip resets.
// R22 - Host queries status after every other command.
// R23 - Once one link talks, the other is ignored.
// R24 - Sum modulo 256; bad sum or length is rejected.
// R25 - Commands other than a status query update status; bad codes and orphan writes fail.
module serial_loader (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire loader_pkg::link_byte_type link_a_rx,
    input  wire logic                      link_a_tx_ready,
    output loader_pkg::link_byte_type      link_a_tx,
    input  wire loader_pkg::link_byte_type link_b_rx,
    input  wire logic                      link_b_tx_ready,
    output loader_pkg::link_byte_type      link_b_tx,
    output loader_pkg::flash_req_type      flash_req,
    input  wire loader_pkg::flash_ans_type flash_ans,
    output loader_pkg::exec_type           exec_out
);
    import loader_pkg::*;

    typedef struct packed {
        state_type     state;
        logic [7:0]    len;
        logic [7:0]    left_rx;
        logic [7:0]    sum_rx;
        logic [7:0]    sum_calc;
        logic [7:0]    pidx;
        logic [7:0]    cmd;
        logic [63:0]   param;
        logic [7:0]    status;
        logic [31:0]   prog_addr;
        logic [31:0]   prog_left;
        logic          session;
        logic [7:0]    tx_byte;
        logic          ack_ok;
        logic [1:0]    seq;
        logic [`BUF_AW-1:0] idx;
        logic [7:0]    n;
        flash_req_type freq;
        exec_type      ex;
    } loader_state_type;

    loader_state_type   s_reg;
    loader_state_type   s_next;
    link_byte_type      rx;
    logic               busy;
    logic               send;
    logic               buf_we;
    logic [7:0]         buf_rdata;
    logic [`BUF_AW-1:0] buf_waddr;
    logic               rx_nonzero;
    logic [32:0]        area_end;
    logic [7:0]         data_cnt;

    link_select u_link (
        .clk        (clk),
        .reset_n    (reset_n),
        .a_rx       (link_a_rx),
        .a_tx_ready (link_a_tx_ready),
        .a_tx       (link_a_tx),
        .b_rx       (link_b_rx),
        .b_tx_ready (link_b_tx_ready),
        .b_tx       (link_b_tx),
        .rx         (rx),
        .send       (send),
        .send_data  (s_reg.tx_byte),
        .busy       (busy)
    );

    payload_mem #(
        .WIDTH (8),
        .DEPTH (`BUF_DEPTH),
        .AW    (`BUF_AW)
    ) u_buf (
        .clk     (clk),
        .wr_en   (buf_we),
        .wr_addr (buf_waddr),
        .wr_data (rx.data),
        .rd_addr (s_reg.idx),
        .rd_data (buf_rdata)
    );

    // Data bytes land in the buffer as they arrive.
    assign rx_nonzero = rx.valid & (rx.data != `ZERO_BYTE);
    assign buf_waddr  = s_reg.pidx[`BUF_AW-1:0] - {{(`BUF_AW-1){1'b0}}, 1'b1};
    assign buf_we     = (s_reg.state == ST_BODY) & rx.valid & (s_reg.pidx != 8'h00)
                        & (s_reg.pidx <= `BUF_DEPTH);
    assign send       = (s_reg.state == ST_SEND) & ~busy;
    assign area_end   = {1'b0, s_reg.param[63:32]} + {1'b0, s_reg.param[31:0]};
    assign data_cnt   = s_reg.len - `LEN_MIN;

    assign flash_req  = s_reg.freq;
    assign exec_out   = s_reg.ex;

    // Packet receive, execution and reply.
    always_comb begin
        s_next = s_reg;
        s_next.freq.erase_req = 1'b0;
        s_next.freq.prog_req  = 1'b0;
        s_next.ex.run_req     = 1'b0;
        s_next.ex.reset_req   = 1'b0;
        case (s_reg.state)
            ST_IDLE: begin
                // First non-zero byte is the length.
                if (rx_nonzero) begin // see R9
                    s_next.len      = rx.data; // see R1
                    s_next.left_rx  = rx.data - `HDR_BYTES; // see R3
                    s_next.sum_calc = `ZERO_BYTE;
                    s_next.pidx     = 8'h00;
                    s_next.param    = '0;
                    s_next.seq      = `SEQ_ACK;
                    if (rx.data < `LEN_MIN || rx.data > `LEN_MAX) begin
                        s_next.ack_ok  = 1'b0;
                        s_next.tx_byte = `NAK_BYTE; // see R24
                        s_next.state   = ST_SEND;
                    end else begin
                        s_next.state = ST_SUM;
                    end
                end
            end
            ST_SUM: begin
                if (rx.valid) begin
                    s_next.sum_rx = rx.data; // see R2
                    s_next.state  = ST_BODY;
                end
            end
            ST_BODY: begin
                if (rx.valid) begin
                    // Modulo-256 sum over payload bytes only.
                    s_next.sum_calc = s_reg.sum_calc + rx.data; // see R2, R24
                    s_next.pidx     = s_reg.pidx + 8'h01;
                    s_next.left_rx  = s_reg.left_rx - 8'h01;
                    if (s_reg.pidx == 8'h00) begin
                        s_next.cmd = rx.data; // see R10
                    end else if (s_reg.pidx <= `PARAM_BYTES) begin
                        s_next.param = {s_reg.param[55:0], rx.data}; // see R13
                    end
                    if (s_reg.left_rx == 8'h01) begin
                        s_next.state = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                s_next.ack_ok  = 1'b1;
                s_next.tx_byte = `ACK_BYTE; // see R4, R5
                s_next.state   = ST_SEND;
                if (s_reg.sum_calc != s_reg.sum_rx) begin
                    // Bad packets change nothing.
                    s_next.ack_ok  = 1'b0;
                    s_next.tx_byte = `NAK_BYTE; // see R19, R24
                end else begin
                    case (s_reg.cmd)
                        `CMD_PING: begin
                            s_next.status = (s_reg.len == `LEN_PING) ? `STAT_SUCCESS
                                                                      : `STAT_UNKNOWN_CMD; // see R11
                        end
                        `CMD_QUERY_RESULT: begin
                            if (s_reg.len != `LEN_QUERY_RESULT) begin
                                s_next.status = `STAT_UNKNOWN_CMD;
                            end
                        end
                        `CMD_DOWNLOAD: begin
                            s_next.session = 1'b0;
                            if (s_reg.len == `LEN_DOWNLOAD && area_end <= `FLASH_BYTES) begin
                                s_next.prog_addr      = s_reg.param[63:32];
                                s_next.prog_left      = s_reg.param[31:0];
                                s_next.freq.addr      = s_reg.param[63:32];
                                s_next.freq.size      = s_reg.param[31:0];
                                s_next.freq.erase_req = 1'b1; // see R14
                                s_next.state          = ST_ERASE;
                            end else begin
                                s_next.status = `STAT_INVALID_ARG; // see R15
                            end
                        end
                        `CMD_SEND_DATA: begin
                            if (!s_reg.session) begin
                                s_next.status = `STAT_INVALID_ARG; // see R16, R25
                            end else if (data_cnt == 8'h00 || s_reg.prog_left == 32'h0) begin
                                s_next.status = `STAT_SUCCESS;
                            end else begin
                                s_next.idx = '0;
                                // Bytes beyond the announced total are dropped.
                                s_next.n = (s_reg.prog_left < {24'h0, data_cnt})
                                           ? s_reg.prog_left[7:0] : data_cnt; // see R18
                                s_next.state = ST_PROG_RD;
                            end
                        end
                        `CMD_RUN: begin
                            s_next.status = (s_reg.len == `LEN_RUN) ? `STAT_SUCCESS
                                                                     : `STAT_UNKNOWN_CMD;
                        end
                        `CMD_RESET: begin
                            s_next.status = (s_reg.len == `LEN_RESET) ? `STAT_SUCCESS
                                                                       : `STAT_UNKNOWN_CMD;
                        end
                        default: begin
                            s_next.status = `STAT_UNKNOWN_CMD; // see R25
                        end
                    endcase
                end
            end
            ST_ERASE: begin
                // The acknowledge waits for the erase to complete.
                if (flash_ans.done) begin
                    s_next.status  = flash_ans.ok ? `STAT_SUCCESS : `STAT_FLASH_FAIL; // see R14
                    s_next.session = flash_ans.ok;
                    s_next.state   = ST_SEND;
                end
            end
            ST_PROG_RD: begin
                s_next.state = ST_PROG_LD;
            end
            ST_PROG_LD: begin
                s_next.freq.addr     = s_reg.prog_addr;
                s_next.freq.data     = buf_rdata;
                s_next.freq.prog_req = 1'b1;
                s_next.state         = ST_PROG_WAIT;
            end
            ST_PROG_WAIT: begin
                if (flash_ans.done) begin
                    if (!flash_ans.ok) begin
                        s_next.status  = `STAT_FLASH_FAIL;
                        s_next.session = 1'b0;
                        s_next.state   = ST_SEND;
                    end else begin
                        // Consecutive writes continue from the next address.
                        s_next.prog_addr = s_reg.prog_addr + 32'h1; // see R16
                        s_next.prog_left = s_reg.prog_left - 32'h1; // see R18
                        s_next.idx       = s_reg.idx + {{(`BUF_AW-1){1'b0}}, 1'b1};
                        s_next.n         = s_reg.n - 8'h01;
                        if (s_reg.n == 8'h01) begin
                            s_next.status = `STAT_SUCCESS;
                            s_next.state  = ST_SEND;
                        end else begin
                            s_next.state = ST_PROG_RD;
                        end
                    end
                end
            end
            ST_SEND: begin
                // Next byte leaves once the link is free.
                if (!busy) begin
                    s_next.state = ST_IDLE;
                    if (s_reg.ack_ok && s_reg.cmd == `CMD_QUERY_RESULT
                        && s_reg.len == `LEN_QUERY_RESULT) begin // see R12
                        s_next.seq   = s_reg.seq + 2'h1;
                        s_next.state = ST_SEND; // see R7
                        case (s_reg.seq)
                            `SEQ_ACK:  s_next.tx_byte = `LEN_REPLY; // see R6
                            `SEQ_SUM:  s_next.tx_byte = s_reg.status;
                            `SEQ_DATA: s_next.tx_byte = s_reg.status;
                            default:   s_next.state   = ST_REPLY;
                        endcase
                    end else if (s_reg.ack_ok && s_reg.cmd == `CMD_RUN
                                 && s_reg.len == `LEN_RUN) begin
                        s_next.ex.addr = s_reg.param[31:0];
                        s_next.state   = ST_HOLD; // see R20
                    end else if (s_reg.ack_ok && s_reg.cmd == `CMD_RESET
                                 && s_reg.len == `LEN_RESET) begin
                        s_next.state = ST_HOLD; // see R21
                    end
                end
            end
            ST_HOLD: begin
                // Hand-over waits for the acknowledge to leave.
                if (!busy) begin
                    s_next.ex.run_req   = (s_reg.cmd == `CMD_RUN); // see R20
                    s_next.ex.reset_req = (s_reg.cmd == `CMD_RESET); // see R21
                    s_next.state        = ST_IDLE;
                end
            end
            ST_REPLY: begin
                // Any host answer ends the exchange.
                if (rx_nonzero) begin // see R8, R9
                    s_next.state = ST_IDLE;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg        <= '0;
            s_reg.state  <= ST_IDLE;
            s_reg.status <= `STAT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : serial_loader

// ===== sim/host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic                      clk,
    output loader_pkg::link_byte_type      rx,
    input  wire loader_pkg::link_byte_type tx,
    output logic                           tx_ready
);
    import loader_pkg::*;
    // The link starts idle.
    initial begin
        rx = '0;
        tx_ready = 1'b0;
    end
    // Sends bytes back to back, then drops the strobe.
    task automatic raw(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(negedge clk);
            rx = {1'b1, q[i]};
        end
        @(negedge clk);
        rx = {1'b0, ~rx.data};
    endtask : raw
    // Frames a payload; bad spoils the sum.
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [7:0] s;
        s = 8'h00;
        foreach (q[i]) s += q[i];
        q.push_front(s ^ {7'h0, bad});
        q.push_front(8'(q.size() + 1));
        raw(q);
    endtask : send
    // Takes one byte, stalling at random.
    task automatic get(output logic [7:0] b);
        do begin
            @(negedge clk);
            tx_ready = 1'($urandom);
            @(posedge clk);
        end while (!(tx.valid && tx_ready));
        b = tx.data;
        @(negedge clk);
        tx_ready = 1'b0;
    endtask : get
endmodule : host_model

// ===== sim/serial_loader_asserts.sv
`timescale 1ns/1ps
module serial_loader_asserts (
    input wire logic                      clk,
    input wire logic                      reset_n,
    input wire loader_pkg::link_byte_type link_a_rx,
    input wire logic                      link_a_tx_ready,
    input wire loader_pkg::link_byte_type link_a_tx,
    input wire loader_pkg::link_byte_type link_b_rx,
    input wire logic                      link_b_tx_ready,
    input wire loader_pkg::link_byte_type link_b_tx,
    input wire loader_pkg::flash_req_type flash_req,
    input wire loader_pkg::flash_ans_type flash_ans,
    input wire loader_pkg::exec_type      exec_out
);
    import loader_pkg::*;
    logic a_used_reg, b_used_reg, erasing_reg, ack_taken;
    // An acknowledge byte is consumed by either link in this cycle.
    assign ack_taken = (link_a_tx.valid && link_a_tx_ready && link_a_tx.data == 8'hcc)
        || (link_b_tx.valid && link_b_tx_ready && link_b_tx.data == 8'hcc);
    // Remember which link has talked and whether an erase is still open.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            a_used_reg  <= 1'b0;
            b_used_reg  <= 1'b0;
            erasing_reg <= 1'b0;
        end else begin
            a_used_reg  <= a_used_reg | link_a_tx.valid;
            b_used_reg  <= b_used_reg | link_b_tx.valid;
            erasing_reg <= flash_req.erase_req | (erasing_reg & ~flash_ans.done);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_A_STANDS: assert property (
        link_a_tx.valid && !link_a_tx_ready |=> link_a_tx.valid && $stable(link_a_tx.data))
        else $error("link A byte not held");
    AST_B_STANDS: assert property (
        link_b_tx.valid && !link_b_tx_ready |=> link_b_tx.valid && $stable(link_b_tx.data))
        else $error("link B byte not held");
    AST_ERASE_QUIET: assert property (
        erasing_reg |-> !link_a_tx.valid && !link_b_tx.valid)
        else $error("answer during erase");
    AST_ERASE_ACK: assert property (
        $fell(erasing_reg) |-> ##[0:3] (link_a_tx.valid || link_b_tx.valid))
        else $error("no answer after erase");
    AST_RUN_AFTER_ACK: assert property (
        exec_out.run_req |-> $past(ack_taken, 2))
        else $error("run before acknowledge");
    AST_RESET_AFTER_ACK: assert property (
        exec_out.reset_req |-> $past(ack_taken, 2))
        else $error("reset before acknowledge");
    AST_LINK_LOCK: assert property (
        !(a_used_reg && link_b_tx.valid) && !(b_used_reg && link_a_tx.valid))
        else $error("second link answered");
    AST_PROG_SINGLE: assert property (
        flash_req.prog_req |=> (!flash_req.prog_req && !flash_req.erase_req) [*2])
        else $error("flash requests too close");
endmodule : serial_loader_asserts

bind serial_loader serial_loader_asserts chk_u (.clk(clk), .reset_n(reset_n),
    .link_a_rx(link_a_rx), .link_a_tx_ready(link_a_tx_ready), .link_a_tx(link_a_tx),
    .link_b_rx(link_b_rx), .link_b_tx_ready(link_b_tx_ready), .link_b_tx(link_b_tx),
    .flash_req(flash_req), .flash_ans(flash_ans), .exec_out(exec_out));

// ===== sim/serial_loader_tb_top.sv
`timescale 1ns/1ps
`include "loader_defs.svh"
module serial_loader_tb_top;
    import loader_pkg::*;
    logic          clk = 1'b0;
    logic          reset_n = 1'b0;
    link_byte_type a_rx, a_tx, b_tx;
    link_byte_type b_rx = '0;
    logic          a_rdy;
    flash_req_type freq;
    flash_ans_type fans = '0;
    exec_type      ex;
    logic [2:0]    cnt = 3'h0;
    logic [31:0]   pa[$], a;
    logic [7:0]    pd[$], wq[$], b;
    int            failures = 0;
    int            cmp_count = 0;
    // 100 ns clock.
    always #50 clk = ~clk;
    serial_loader dut_u (.clk(clk), .reset_n(reset_n), .link_a_rx(a_rx), .link_a_tx_ready(a_rdy),
        .link_a_tx(a_tx), .link_b_rx(b_rx), .link_b_tx_ready(1'b1), .link_b_tx(b_tx),
        .flash_req(freq), .flash_ans(fans), .exec_out(ex));
    host_model host_u (.clk(clk), .rx(a_rx), .tx(a_tx), .tx_ready(a_rdy));
    // Flash stand-in with a random answer delay.
    always @(negedge clk) begin
        fans <= '0;
        if (freq.erase_req || freq.prog_req) begin
            cnt <= 3'h1 + 3'($urandom % 6);
            if (freq.prog_req) pa.push_back(freq.addr);
            if (freq.prog_req) pd.push_back(freq.data);
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            fans <= {cnt == 3'h1, 1'b1};
        end
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] q[$], input logic bad, input logic [7:0] e);
        host_u.send(q, bad);
        host_u.get(b);
        chk("answer byte", b, e);
    endtask : cmd
    // Queries status and answers the reply after zero padding.
    task automatic status(input logic [7:0] e);
        cmd('{`CMD_QUERY_RESULT}, 1'b0, `ACK_BYTE);
        for (int i = 0; i < 3; i++) begin
            host_u.get(b);
            chk("reply byte", b, (i == 0) ? `LEN_REPLY : e);
        end
        host_u.raw('{8'h00, 8'h00, `ACK_BYTE});
    endtask : status
    function automatic logic [7:0] dl_exp(input logic [31:0] ad, input logic [31:0] sz);
        return ({1'b0, ad} + {1'b0, sz} <= `FLASH_BYTES) ? `STAT_SUCCESS : `STAT_INVALID_ARG;
    endfunction : dl_exp
    task automatic dl(input logic [31:0] ad, input logic [31:0] sz);
        cmd('{`CMD_DOWNLOAD, ad[31:24], ad[23:16], ad[15:8], ad[7:0], sz[31:24], sz[23:16],
            sz[15:8], sz[7:0]}, 1'b0, `ACK_BYTE);
        if (dl_exp(ad, sz) == `STAT_SUCCESS) chk("erase area", freq.addr ^ freq.size, ad ^ sz);
        status(dl_exp(ad, sz));
    endtask : dl
    task automatic summarize();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    // Corner cases mixed with random values.
    initial begin
        void'($urandom(66));
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        cmd('{`CMD_PING}, 1'b0, `ACK_BYTE);
        status(`STAT_SUCCESS);
        cmd('{`CMD_RESET}, 1'b1, `NAK_BYTE);
        status(`STAT_SUCCESS);
        cmd('{8'h30}, 1'b0, `ACK_BYTE);
        status(`STAT_UNKNOWN_CMD);
        cmd('{`CMD_SEND_DATA, 8'h5a}, 1'b0, `ACK_BYTE);
        status(`STAT_INVALID_ARG);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            b_rx = {i < 3, (i == 3) ? 8'hdf : ((i == 0) ? 8'h03 : 8'h20)};
        end
        repeat (12) @(negedge clk);
        chk("link B silent", b_tx.valid, 1'b0);
        a = {17'h0, 15'($urandom)};
        dl(a, 32'h5);
        wq = '{`CMD_SEND_DATA};
        repeat (8) wq.push_back(8'($urandom));
        cmd(wq, 1'b1, `NAK_BYTE);
        chk("nak programs", 32'(pa.size()), 32'h0);
        cmd(wq, 1'b0, `ACK_BYTE);
        chk("programmed count", 32'(pa.size()), 32'h5);
        foreach (pa[i]) chk("prog addr", pa[i], a + 32'(i));
        foreach (pd[i]) chk("prog data", pd[i], wq[i + 1]);
        status(`STAT_SUCCESS);
        for (int k = 0; k < 2; k++) dl(32'hfff0, 32'h10 + 32'(k));
        a = $urandom;
        cmd('{`CMD_RUN, a[31:24], a[23:16], a[15:8], a[7:0]}, 1'b0, `ACK_BYTE);
        @(negedge clk);
        chk("run pulse", {31'h0, ex.run_req}, 32'h1);
        chk("run address", ex.addr, a);
        cmd('{`CMD_RESET}, 1'b0, `ACK_BYTE);
        @(negedge clk);
        chk("reset pulse", {31'h0, ex.reset_req}, 32'h1);
        summarize();
    end
    // Watchdog against a hung handshake.
    initial begin
        #3000000;
        failures++;
        summarize();
    end
endmodule : serial_loader_tb_top
